// file: src/core_pkg.sv
// constants, opcodes and types shared by the execute core
//Contract
//- halt bumps pc, stops clock, keeps state
//- halt clears watchdog counter and prescaler
//- halt sets sleep flag, clears watchdog flag
//- increment writes byte plus one, zero flag
//- increment-to-acc loads acc, memory kept
//- jump loads pc bits 0 to 10
//- move memory byte to acc, no flags
//- move immediate to acc, no flags
//- move acc to memory, no flags
//- no-op only advances the pc
//- or into acc, zero flag only
//- or-to-memory writes byte, zero flag
//- return pops pc, two cycles, no flags
//- return with constant also loads acc
//- return from irq sets master enable
//- rotate left, bit 7 into bit 0
//- rotate right, bit 0 into bit 7
//- left through carry, nine-bit rotation
//- right through carry, nine-bit rotation
//- acc-destination rotates keep memory byte
//- borrow subtract into acc, four flags
//- borrow subtract into memory, same flags
//- decrement writes back, skip on zero
//- taken skip adds one dummy cycle
package core_pkg;
    localparam int PC_W = 11;
    localparam int IW = 14;
    localparam int PROG_DEPTH = 2048;
    localparam int DADDR_W = 6;
    localparam int DMEM_DEPTH = 64;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    localparam logic [7:0] OFS_IRQ = 8'h10;
    localparam logic [7:0] OFS_PADDR = 8'h14;
    localparam logic [7:0] OFS_PDATA = 8'h18;
    localparam logic [7:0] OFS_MADDR = 8'h1c;
    localparam logic [7:0] OFS_MDATA = 8'h20;
    localparam logic [7:0] OFS_STACK = 8'h24;
    localparam int CTRL_RUN = 0;
    localparam int IRQ_MASTER = 0;
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_PD = 4;
    localparam int FLG_TO = 5;
    localparam logic [5:0] STATUS_RST = 6'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [2:0] JMP_PFX = 3'h7;
    localparam logic [5:0] OP_HALT = 6'h00;
    localparam logic [5:0] OP_INC = 6'h01;
    localparam logic [5:0] OP_INCA = 6'h02;
    localparam logic [5:0] OP_MOVAM = 6'h03;
    localparam logic [5:0] OP_MOVAX = 6'h04;
    localparam logic [5:0] OP_MOVMA = 6'h05;
    localparam logic [5:0] OP_NOP = 6'h06;
    localparam logic [5:0] OP_ORAM = 6'h07;
    localparam logic [5:0] OP_ORAX = 6'h08;
    localparam logic [5:0] OP_ORM = 6'h09;
    localparam logic [5:0] OP_RET = 6'h0a;
    localparam logic [5:0] OP_RETAX = 6'h0b;
    localparam logic [5:0] OP_RETURN_FROM_IRQ = 6'h0c;
    localparam logic [5:0] OP_RL = 6'h0d;
    localparam logic [5:0] OP_RLA = 6'h0e;
    localparam logic [5:0] OP_RR = 6'h0f;
    localparam logic [5:0] OP_RRA = 6'h10;
    localparam logic [5:0] OP_RLC = 6'h11;
    localparam logic [5:0] OP_RLCA = 6'h12;
    localparam logic [5:0] OP_RRC = 6'h13;
    localparam logic [5:0] OP_RRCA = 6'h14;
    localparam logic [5:0] OP_SBC = 6'h15;
    localparam logic [5:0] OP_SUBTRACT_WITH_BORROW_MEM = 6'h16;
    localparam logic [5:0] OP_SDZ = 6'h17;
    typedef enum logic [3:0] {
        ALU_M, ALU_X, ALU_A, ALU_INC, ALU_DEC, ALU_ORM, ALU_ORX,
        ALU_RL, ALU_RR, ALU_RLC, ALU_RRC, ALU_SBC
    } alu_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY, ST_HALT} state_t;
endpackage

// file: src/core_alu.sv
// byte datapath: result and flag values for one instruction
`timescale 1ns/1ps
`default_nettype none
module core_alu (
    input wire core_pkg::alu_op_t op_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] mem_in,
    input wire logic [7:0] imm_in,
    input wire logic carry_in,
    output logic [7:0] res_out,
    output logic c_out,
    output logic ac_out,
    output logic ov_out,
    output logic z_out
);
    logic [8:0] sub_sum;
    logic [4:0] sub_low;

    always_comb begin
        sub_sum = {1'b0, acc_in} + {1'b0, ~mem_in} + {8'h00, carry_in};
        sub_low = {1'b0, acc_in[3:0]} + {1'b0, ~mem_in[3:0]} + {4'h0, carry_in};
        res_out = mem_in;
        c_out = carry_in;
        ac_out = 1'b0;
        ov_out = 1'b0;
        case (op_in)
            core_pkg::ALU_X: res_out = imm_in;
            core_pkg::ALU_A: res_out = acc_in;
            core_pkg::ALU_INC: res_out = mem_in + 8'h01;
            core_pkg::ALU_DEC: res_out = mem_in - 8'h01;
            core_pkg::ALU_ORM: res_out = acc_in | mem_in;
            core_pkg::ALU_ORX: res_out = acc_in | imm_in;
            core_pkg::ALU_RL: res_out = {mem_in[6:0], mem_in[7]};
            core_pkg::ALU_RR: res_out = {mem_in[0], mem_in[7:1]};
            core_pkg::ALU_RLC: begin
                res_out = {mem_in[6:0], carry_in};
                c_out = mem_in[7];
            end
            core_pkg::ALU_RRC: begin
                res_out = {carry_in, mem_in[7:1]};
                c_out = mem_in[0];
            end
            core_pkg::ALU_SBC: begin
                res_out = sub_sum[7:0];
                c_out = sub_sum[8];
                ac_out = sub_low[4];
                ov_out = (acc_in[7] == ~mem_in[7]) && (sub_sum[7] != acc_in[7]);
            end
            default: res_out = mem_in;
        endcase
        z_out = (res_out == 8'h00);
    end
endmodule
`default_nettype wire

// file: src/core_exec.sv
// execute core: decode, datapath, return stack and apb register file
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module core_exec (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic clk_stop_out,
    output logic wdt_clear_out,
    output logic irq_enable_out
);
    logic [core_pkg::IW-1:0] prog_mem [core_pkg::PROG_DEPTH];
    logic [7:0] dmem [core_pkg::DMEM_DEPTH];
    logic [core_pkg::PC_W-1:0] stk_mem [2];
    logic [1:0] stk_cnt_reg;
    core_pkg::state_t state_reg;
    core_pkg::state_t state_next;
    logic [core_pkg::PC_W-1:0] pc_reg;
    logic [7:0] acc_reg;
    logic [5:0] status_reg;
    logic [7:0] irq_setup_reg;
    logic [core_pkg::PC_W-1:0] prog_addr_reg;
    logic [core_pkg::DADDR_W-1:0] mem_addr_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic clk_stop_reg;
    logic wdt_clear_reg;
    logic [core_pkg::IW-1:0] instr;
    logic [5:0] opcode;
    logic [core_pkg::DADDR_W-1:0] ea;
    logic [7:0] mem_rd;
    logic [core_pkg::PC_W-1:0] stk_top;
    logic is_jmp;
    core_pkg::alu_op_t alu_op;
    logic wr_acc;
    logic wr_mem;
    logic upd_z;
    logic upd_c;
    logic upd_sub;
    logic do_ret;
    logic do_return_from_irq;
    logic do_halt;
    logic do_skip;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_ac;
    logic alu_ov;
    logic alu_z;
    logic busy;
    logic setup;
    logic wr_fire;
    logic ctrl_wr;
    logic run_req;
    logic stop_req;
    logic exec_go;
    logic [31:0] rd_data;
    logic unmapped;
    logic acc_err;
    logic [8:0] chk_sum;

    assign instr = prog_mem[pc_reg];
    assign opcode = instr[13:8];
    assign ea = instr[core_pkg::DADDR_W-1:0];
    assign mem_rd = dmem[ea];
    assign is_jmp = (instr[13:11] == core_pkg::JMP_PFX);
    // an empty stack pops entry zero rather than garbage
    assign stk_top = (stk_cnt_reg == 2'h2) ? stk_mem[1] : stk_mem[0];
    assign busy = (state_reg == core_pkg::ST_EXEC) || (state_reg == core_pkg::ST_DUMMY);

    always_comb begin
        alu_op = core_pkg::ALU_M;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_sub = 1'b0;
        do_ret = 1'b0;
        do_return_from_irq = 1'b0;
        do_halt = 1'b0;
        if (!is_jmp) begin
            case (opcode)
                core_pkg::OP_HALT: do_halt = 1'b1;
                core_pkg::OP_INC: begin
                    alu_op = core_pkg::ALU_INC;
                    wr_mem = 1'b1;
                    upd_z = 1'b1;
                end
                core_pkg::OP_INCA: begin
                    alu_op = core_pkg::ALU_INC;
                    wr_acc = 1'b1;
                    upd_z = 1'b1;
                end
                core_pkg::OP_MOVAM: wr_acc = 1'b1;
                core_pkg::OP_MOVAX: begin
                    alu_op = core_pkg::ALU_X;
                    wr_acc = 1'b1;
                end
                core_pkg::OP_MOVMA: begin
                    alu_op = core_pkg::ALU_A;
                    wr_mem = 1'b1;
                end
                core_pkg::OP_ORAM: begin
                    alu_op = core_pkg::ALU_ORM;
                    wr_acc = 1'b1;
                    upd_z = 1'b1;
                end
                core_pkg::OP_ORAX: begin
                    alu_op = core_pkg::ALU_ORX;
                    wr_acc = 1'b1;
                    upd_z = 1'b1;
                end
                core_pkg::OP_ORM: begin
                    alu_op = core_pkg::ALU_ORM;
                    wr_mem = 1'b1;
                    upd_z = 1'b1;
                end
                core_pkg::OP_RET: do_ret = 1'b1;
                core_pkg::OP_RETAX: begin
                    alu_op = core_pkg::ALU_X;
                    wr_acc = 1'b1;
                    do_ret = 1'b1;
                end
                core_pkg::OP_RETURN_FROM_IRQ: begin
                    do_ret = 1'b1;
                    do_return_from_irq = 1'b1;
                end
                core_pkg::OP_RL: begin
                    alu_op = core_pkg::ALU_RL;
                    wr_mem = 1'b1;
                end
                core_pkg::OP_RLA: begin
                    alu_op = core_pkg::ALU_RL;
                    wr_acc = 1'b1;
                end
                core_pkg::OP_RR: begin
                    alu_op = core_pkg::ALU_RR;
                    wr_mem = 1'b1;
                end
                core_pkg::OP_RRA: begin
                    alu_op = core_pkg::ALU_RR;
                    wr_acc = 1'b1;
                end
                core_pkg::OP_RLC, core_pkg::OP_RLCA: begin
                    alu_op = core_pkg::ALU_RLC;
                    wr_mem = (opcode == core_pkg::OP_RLC);
                    wr_acc = (opcode == core_pkg::OP_RLCA);
                    upd_c = 1'b1;
                end
                core_pkg::OP_RRC, core_pkg::OP_RRCA: begin
                    alu_op = core_pkg::ALU_RRC;
                    wr_mem = (opcode == core_pkg::OP_RRC);
                    wr_acc = (opcode == core_pkg::OP_RRCA);
                    upd_c = 1'b1;
                end
                core_pkg::OP_SBC, core_pkg::OP_SUBTRACT_WITH_BORROW_MEM: begin
                    alu_op = core_pkg::ALU_SBC;
                    wr_acc = (opcode == core_pkg::OP_SBC);
                    wr_mem = (opcode == core_pkg::OP_SUBTRACT_WITH_BORROW_MEM);
                    upd_z = 1'b1;
                    upd_c = 1'b1;
                    upd_sub = 1'b1;
                end
                core_pkg::OP_SDZ: begin
                    alu_op = core_pkg::ALU_DEC;
                    wr_mem = 1'b1;
                end
                default: wr_acc = 1'b0;
            endcase
        end
    end

    core_alu u_alu (
        .op_in(alu_op),
        .acc_in(acc_reg),
        .mem_in(mem_rd),
        .imm_in(instr[7:0]),
        .carry_in(status_reg[core_pkg::FLG_C]),
        .res_out(alu_res),
        .c_out(alu_c),
        .ac_out(alu_ac),
        .ov_out(alu_ov),
        .z_out(alu_z)
    );

    assign do_skip = !is_jmp && (opcode == core_pkg::OP_SDZ) && alu_z;

    // apb: zero wait states, answer in the access cycle
    assign setup = psel_in && !penable_in;
    assign wr_fire = psel_in && penable_in && pwrite_in && pready_reg && !pslverr_reg;
    assign ctrl_wr = wr_fire && (paddr_in == core_pkg::OFS_CTRL);
    assign run_req = ctrl_wr && pwdata_in[core_pkg::CTRL_RUN];
    assign stop_req = ctrl_wr && !pwdata_in[core_pkg::CTRL_RUN];
    assign exec_go = (state_reg == core_pkg::ST_EXEC) && !stop_req;

    always_comb begin
        unmapped = 1'b0;
        rd_data = 32'h0000_0000;
        case (paddr_in)
            core_pkg::OFS_CTRL: rd_data = {30'h0, state_reg == core_pkg::ST_HALT, busy};
            core_pkg::OFS_STATUS: rd_data = {26'h0, status_reg};
            core_pkg::OFS_ACC: rd_data = {24'h0, acc_reg};
            core_pkg::OFS_PC: rd_data = {21'h0, pc_reg};
            core_pkg::OFS_IRQ: rd_data = {24'h0, irq_setup_reg};
            core_pkg::OFS_PADDR: rd_data = {21'h0, prog_addr_reg};
            core_pkg::OFS_PDATA: rd_data = {18'h0, prog_mem[prog_addr_reg]};
            core_pkg::OFS_MADDR: rd_data = {26'h0, mem_addr_reg};
            core_pkg::OFS_MDATA: rd_data = {24'h0, dmem[mem_addr_reg]};
            core_pkg::OFS_STACK: rd_data = {14'h0, stk_cnt_reg, 5'h0, stk_top};
            default: unmapped = 1'b1;
        endcase
        // core state must not change under a running program
        acc_err = unmapped || (pwrite_in && busy && (paddr_in != core_pkg::OFS_CTRL))
            || (pwrite_in && (paddr_in == core_pkg::OFS_STACK) && (stk_cnt_reg == 2'h2));
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                pslverr_reg <= acc_err;
                prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_data;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prog_addr_reg <= core_pkg::PC_RST;
            mem_addr_reg <= '0;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_PADDR)) begin
            prog_addr_reg <= pwdata_in[core_pkg::PC_W-1:0];
        end else if (wr_fire && (paddr_in == core_pkg::OFS_PDATA)) begin
            prog_addr_reg <= prog_addr_reg + 11'h001;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_MADDR)) begin
            mem_addr_reg <= pwdata_in[core_pkg::DADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_fire && (paddr_in == core_pkg::OFS_PDATA)) begin
            prog_mem[prog_addr_reg] <= pwdata_in[core_pkg::IW-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (exec_go && wr_mem) begin
            dmem[ea] <= alu_res;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_MDATA)) begin
            dmem[mem_addr_reg] <= pwdata_in[7:0];
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            core_pkg::ST_IDLE, core_pkg::ST_HALT: begin
                if (run_req) state_next = core_pkg::ST_EXEC;
            end
            core_pkg::ST_EXEC: begin
                if (stop_req) state_next = core_pkg::ST_IDLE;
                else if (do_halt) state_next = core_pkg::ST_HALT;
                else if (do_ret || do_skip) state_next = core_pkg::ST_DUMMY;
            end
            core_pkg::ST_DUMMY: begin
                if (stop_req) state_next = core_pkg::ST_IDLE;
                else state_next = core_pkg::ST_EXEC;
            end
            default: state_next = core_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= core_pkg::ST_IDLE;
            clk_stop_reg <= 1'b0;
            wdt_clear_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            clk_stop_reg <= (state_next == core_pkg::ST_HALT);
            wdt_clear_reg <= exec_go && do_halt;
        end
    end

    // a skip steps over the prefetched word; the dummy cycle then does nothing
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_reg <= core_pkg::PC_RST;
        end else if (exec_go) begin
            if (is_jmp) pc_reg <= instr[core_pkg::PC_W-1:0];
            else if (do_ret) pc_reg <= stk_top;
            else if (do_skip) pc_reg <= pc_reg + 11'h002;
            else pc_reg <= pc_reg + 11'h001;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_PC)) begin
            pc_reg <= pwdata_in[core_pkg::PC_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_reg <= core_pkg::BYTE_RST;
        end else if (exec_go && wr_acc) begin
            acc_reg <= alu_res;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_ACC)) begin
            acc_reg <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_reg <= core_pkg::STATUS_RST;
        end else if (exec_go) begin
            if (do_halt) begin
                status_reg[core_pkg::FLG_PD] <= 1'b1;
                status_reg[core_pkg::FLG_TO] <= 1'b0;
            end
            if (upd_z) status_reg[core_pkg::FLG_Z] <= alu_z;
            if (upd_c) status_reg[core_pkg::FLG_C] <= alu_c;
            if (upd_sub) begin
                status_reg[core_pkg::FLG_AC] <= alu_ac;
                status_reg[core_pkg::FLG_OV] <= alu_ov;
            end
        end else if (wr_fire && (paddr_in == core_pkg::OFS_STATUS)) begin
            status_reg <= pwdata_in[5:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_setup_reg <= core_pkg::BYTE_RST;
        end else if (exec_go && do_return_from_irq) begin
            irq_setup_reg[core_pkg::IRQ_MASTER] <= 1'b1;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_IRQ)) begin
            irq_setup_reg <= pwdata_in[7:0];
        end
    end

    // stack is filled over the bus; no call instruction lives in this core
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stk_cnt_reg <= 2'h0;
        end else if (exec_go && do_ret) begin
            if (stk_cnt_reg != 2'h0) stk_cnt_reg <= stk_cnt_reg - 2'h1;
        end else if (wr_fire && (paddr_in == core_pkg::OFS_STACK)) begin
            stk_cnt_reg <= stk_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_fire && (paddr_in == core_pkg::OFS_STACK)) begin
            stk_mem[stk_cnt_reg[0]] <= pwdata_in[core_pkg::PC_W-1:0];
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign clk_stop_out = clk_stop_reg;
    assign wdt_clear_out = wdt_clear_reg;
    assign irq_enable_out = irq_setup_reg[core_pkg::IRQ_MASTER];

    assign chk_sum = {1'b0, acc_reg} + {1'b0, ~mem_rd} + {8'h00, status_reg[core_pkg::FLG_C]};

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_halt_stop: assert property (exec_go && do_halt |=> clk_stop_out
        && state_reg == core_pkg::ST_HALT && pc_reg == $past(pc_reg) + 11'h001)
        else $error("halt did not stop with pc advanced");
    a_halt_wdt: assert property (exec_go && do_halt |=> wdt_clear_out ##1 !wdt_clear_out)
        else $error("watchdog clear not a single pulse");
    a_halt_flags: assert property (exec_go && do_halt |=> status_reg[core_pkg::FLG_PD]
        && !status_reg[core_pkg::FLG_TO] && status_reg[3:0] == $past(status_reg[3:0]))
        else $error("halt flags wrong");
    a_inc_mem: assert property (exec_go && opcode == core_pkg::OP_INC
        |=> dmem[$past(ea)] == $past(mem_rd) + 8'h01)
        else $error("increment result wrong");
    a_jmp_pc: assert property (exec_go && is_jmp
        |=> pc_reg == $past(instr[10:0]) && $stable(status_reg))
        else $error("jump target wrong");
    a_mov_imm: assert property (exec_go && opcode == core_pkg::OP_MOVAX
        |=> acc_reg == $past(instr[7:0]) && $stable(status_reg))
        else $error("immediate load wrong");
    a_ret_pop: assert property (exec_go && do_ret
        |=> state_reg == core_pkg::ST_DUMMY && pc_reg == $past(stk_top))
        else $error("return did not pop in two cycles");
    a_return_from_irq_enable: assert property (exec_go && do_return_from_irq |=> irq_enable_out)
        else $error("master enable not set");
    a_sbc_carry: assert property (exec_go && opcode == core_pkg::OP_SBC
        |=> status_reg[core_pkg::FLG_C] == $past(chk_sum[8])
        && acc_reg == $past(chk_sum[7:0]))
        else $error("borrow subtract wrong");
    a_skip_dummy: assert property (exec_go && do_skip |=> state_reg == core_pkg::ST_DUMMY
        && pc_reg == $past(pc_reg) + 11'h002 ##1 state_reg != core_pkg::ST_DUMMY)
        else $error("skip timing wrong");
    a_one_cycle: assert property (exec_go && !do_ret && !do_skip && !do_halt
        |=> state_reg == core_pkg::ST_EXEC)
        else $error("single-cycle instruction stalled");

    c_halt: cover property (exec_go && do_halt);
    c_skip: cover property (exec_go && do_skip);
    c_ret: cover property (exec_go && do_ret);
    c_jmp: cover property (exec_go && is_jmp);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// random operand programs run through the execute core, checked over apb
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, er;
    logic [7:0] paddr_in = 8'h00, a0, m1, m2, r;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, clk_stop_out, wdt_clear_out, irq_enable_out;
    logic [8:0] s9;
    logic [4:0] h5;
    logic [10:0] e;
    logic [13:0] pq[$];
    integer mismatches = 0, total_checks = 0, seed = 32'h5eb7f19b, i;
    always #10 clk_in = ~clk_in;
    core_exec dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .clk_stop_out(clk_stop_out),
        .wdt_clear_out(wdt_clear_out), .irq_enable_out(irq_enable_out));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // {signed_wrap, nibble_half, carry, result} of acc plus inverted byte plus carry
    function automatic logic [10:0] sbc_f(input logic [7:0] a, input logic [7:0] m,
        input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~m} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
        return {(a[7] != m[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
    endfunction
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one idle cycle after each transfer keeps every signal to one change per edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        er = pslverr_out;
        if (n >= 20) begin
            mismatches++;
            tally_and_finish();
        end
        psel_in <= 0;
        penable_in <= 0;
        @(posedge clk_in);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        check(what, rd, exp);
    endtask
    task automatic mem(input logic [7:0] a);
        apb(1, 8'h1c, {24'h0, a});
    endtask
    // loads the queued words from address 0, starts at pc 0 and waits for halt
    task automatic run(input logic [10:0] pc_exp, input logic [5:0] st_exp);
        integer k, pulses;
        apb(1, 8'h14, 32'h0);
        foreach (pq[j]) apb(1, 8'h18, {18'h0, pq[j]});
        apb(1, 8'h0c, 32'h0);
        apb(1, 8'h00, 32'h1);
        pulses = 0;
        for (k = 0; k < 200 && clk_stop_out !== 1'b1; k++) begin
            @(posedge clk_in);
            pulses += (wdt_clear_out === 1'b1);
        end
        check("halt wait", k < 200, 1);
        if (k >= 200) tally_and_finish();
        check("wdt clear pulses", pulses, 1);
        rdc("ctrl", 8'h00, 32'h2);
        rdc("pc", 8'h0c, {21'h0, pc_exp});
        rdc("status", 8'h04, {26'h0, st_exp});
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        apb(0, 8'h40, 32'h0);
        check("unmapped err", {31'h0, er}, 1);
        for (i = 0; i < 6; i++) begin
            a0 = (i == 1) ? 8'h80 : $random(seed);
            m1 = (i == 0) ? a0 : (i == 1) ? 8'h01 : $random(seed);
            apb(1, 8'h08, {24'h0, a0});
            apb(1, 8'h04, 32'h21);
            mem(8'h01);
            apb(1, 8'h20, {24'h0, m1});
            mem(8'h02);
            apb(1, 8'h20, 32'h1);
            pq = '{{core_pkg::OP_SBC, 8'h01}, {core_pkg::OP_RLC, 8'h01},
                {core_pkg::OP_SDZ, 8'h02}, {core_pkg::OP_INC, 8'h02},
                {core_pkg::OP_RLA, 8'h01}, 14'h0000};
            s9 = {1'b0, a0} + {1'b0, ~m1} + 9'd1;
            h5 = {1'b0, a0[3:0]} + {1'b0, ~m1[3:0]} + 5'd1;
            m2 = {m1[6:0], s9[8]};
            run(11'h006, {2'b01, (a0[7] != m1[7]) && (s9[7] != a0[7]), s9[7:0] == 8'h00,
                h5[4], m1[7]});
            rdc("acc rla", 8'h08, {24'h0, m2[6:0], m2[7]});
            mem(8'h01);
            rdc("mem rlc", 8'h20, {24'h0, m2});
            mem(8'h02);
            rdc("mem sdz", 8'h20, 32'h0);
            r = $random(seed);
            m1 = (i == 2) ? 8'hff : $random(seed);
            apb(1, 8'h04, 32'h0);
            apb(1, 8'h10, 32'h0);
            mem(8'h03);
            apb(1, 8'h20, {24'h0, m1});
            apb(1, 8'h24, 32'h8);
            apb(1, 8'h24, 32'h4);
            pq = '{{core_pkg::OP_RETAX, r}, 0, 0, 0, {core_pkg::OP_RETURN_FROM_IRQ, 8'h00}, 0, 0, 0,
                {core_pkg::OP_INC, 8'h03}, {core_pkg::OP_ORM, 8'h03},
                {core_pkg::OP_MOVMA, 8'h04}, {3'h7, 11'h020}};
            for (int j = 12; j < 32; j++) pq.push_back({core_pkg::OP_NOP, 8'h00});
            pq.push_back(14'h0000);
            m2 = r | (m1 + 8'h01);
            run(11'h021, {2'b01, 1'b0, m2 == 8'h00, 2'b00});
            check("irq enable", {31'h0, irq_enable_out}, 1);
            rdc("acc ret", 8'h08, {24'h0, r});
            mem(8'h03);
            rdc("mem orm", 8'h20, {24'h0, m2});
            mem(8'h04);
            rdc("mem mov", 8'h20, {24'h0, r});
            // remaining opcodes except nop, rr and rlca: untaken skip must let the increment set zero
            a0 = (i == 3) ? 8'h00 : $random(seed);
            r = $random(seed);
            apb(1, 8'h04, 32'h1);
            apb(1, 8'h24, 32'h2);
            mem(8'h05);
            apb(1, 8'h20, {24'h0, a0});
            mem(8'h06);
            apb(1, 8'h20, 32'h2);
            mem(8'h09);
            apb(1, 8'h20, 32'h0);
            pq = '{{core_pkg::OP_RET, 8'h00}, 0, {core_pkg::OP_RL, 8'h05},
                {core_pkg::OP_RRA, 8'h05}, {core_pkg::OP_MOVMA, 8'h07}, {core_pkg::OP_RRC, 8'h05},
                {core_pkg::OP_RRCA, 8'h06}, {core_pkg::OP_ORAX, r}, {core_pkg::OP_MOVMA, 8'h08},
                {core_pkg::OP_MOVAM, 8'h05}, {core_pkg::OP_ORAM, 8'h06}, {core_pkg::OP_SUBTRACT_WITH_BORROW_MEM, 8'h06},
                {core_pkg::OP_SDZ, 8'h09}, {core_pkg::OP_INCA, 8'h09}, {core_pkg::OP_MOVAX, r},
                14'h2000, 0};
            m2 = {1'b1, a0[6:0]} | 8'h02;
            e = sbc_f(m2, 8'h02, 1'b0);
            run(11'h011, {2'b01, e[10], 1'b1, e[9], e[8]});
            rdc("acc movax", 8'h08, {24'h0, r});
            rdc("stack pop", 8'h24, 32'h2);
            mem(8'h05);
            rdc("mem rrc", 8'h20, {24'h0, 1'b1, a0[6:0]});
            mem(8'h06);
            rdc("mem subtract_with_borrow_mem", 8'h20, {24'h0, e[7:0]});
            mem(8'h07);
            rdc("mem rra", 8'h20, {24'h0, a0});
            mem(8'h08);
            rdc("mem orax", 8'h20, {24'h0, ({a0[7], 7'h01} | r)});
            mem(8'h09);
            rdc("mem inca", 8'h20, 32'hff);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
